// file: design/sac_fifo2.v
`default_nettype none
`include "sac_regs.vh"
// ==========================================================
// Two-entry result buffer
// ==========================================================
module sac_fifo2 (
  input  wire                  mclk,      // Master clock
  input  wire                  srst,      // Sync reset, high
  input  wire                  in_valid,  // Word offered
  output wire                  in_ready,  // Room for a word
  input  wire [`SAC_RES_W-1:0] in_data,   // Word in
  output wire                  out_valid, // Word available
  input  wire                  out_ready, // Reader takes word
  output wire [`SAC_RES_W-1:0] out_data   // Oldest word
);
  reg [`SAC_RES_W-1:0] mem_r [0:1]; // Storage, indexed
  reg                  wr_ptr_r;    // Write index
  reg                  rd_ptr_r;    // Read index
  reg [1:0]            cnt_r;       // Words held
  wire                 do_wr;       // Accepted write
  wire                 do_rd;       // Accepted read

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rd_ptr_r];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  // ========================================================
  // Pointers and occupancy
  // ========================================================
  always @(posedge mclk) begin
    if (srst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      // Write stores at the write index
      if (do_wr) begin
        mem_r[wr_ptr_r] <= in_data;
        wr_ptr_r        <= ~wr_ptr_r;
      end
      if (do_rd) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      // Count moves only when one side acts alone
      if (do_wr & ~do_rd) begin
        cnt_r <= cnt_r + 2'h1;
      end else if (do_rd & ~do_wr) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end
endmodule // sac_fifo2
`default_nettype wire

// file: design/sac_regs.vh
`ifndef SAC_REGS_VH
`define SAC_REGS_VH
// ==========================================================
// Converter widths and codes
// ==========================================================
`define SAC_RES_W      16
`define SAC_MSB        4'hf
`define SAC_ALL_ONES   16'hffff
`define SAC_ALL_ZEROS  16'h0000
// ==========================================================
// Timing counts in master clock cycles
// ==========================================================
// Calibration length after reset release
`define SAC_CAL_CYCLES 34584480
`define SAC_CALCNT_W   26
// Window for the first sample/hold and track controls to fall
`define SAC_SH1_MIN    198
`define SAC_SH1_MAX    214
// Strobe detect lags the pin by four cycles, so 200 lands at 204
`define SAC_SH1_DLY    8'd200
`define SAC_TMR_W      8
// Comparator settling per decision
`define SAC_STEP_CYC   4'h8
// ==========================================================
// Calibration trim storage
// ==========================================================
`define SAC_TRIM_W     5
`define SAC_TRIM_RST   5'h10
`define SAC_TRIM_STEPS 3'h7
`endif

// file: design/sac_top.v
// Summary of operation
// (RQ1) Calibrate fixed cycle count after reset release
// (RQ2) First S/H and tracks fall 198-214
// (RQ3) Controller aligns strobe and channel-select edges
// (RQ4) Out of range saturates all ones/zeros
// (RQ5) Serial output, binary or two's complement
// (RQ6) Track outside conversion, hold during it
// (RQ7) Successive approximation, one bit per step
// (RQ8) Trim each bit against lower sum; bit 0 is never trimmed
// (RQ9) Reset recalibrates, coefficients kept in storage
// (RQ10) Alternate left and right via channel select
// (RQ11) Done flag low during calibration
// (RQ12) Reset clears everything, overrides all; trim coefficients are kept
// (RQ13) Strobe falling edge starts conversion
// (RQ14) Result shifts out during next conversion
// (RQ15) MSB first, stable at serial clock rise
`default_nettype none
`include "sac_regs.vh"
module sac_top #(
  parameter CAL_CYCLES = `SAC_CAL_CYCLES // Shorten in simulation
) (
  input  wire                  mclk,                  // Master clock, 25 MHz
  input  wire                  srst,                  // Sync reset, high
  input  wire                  conv_strobe_n,         // Conversion strobe pin
  input  wire                  chan_sel_left,         // Channel select pin
  input  wire                  serial_clk,            // Serial clock pin
  input  wire                  coding_twos,           // Two's complement select pin
  input  wire                  comp_in,               // Comparator, same domain
  input  wire                  over_pos,              // Input above reference
  input  wire                  under_neg,             // Input below neg reference
  output reg                   calib_done_flag,       // Ready for conversions
  output reg                   ext_sh_ctrl_first,     // External S/H control 1
  output reg                   ext_sh_ctrl_second,    // External S/H control 2
  output reg                   left_track_ctl,        // Left track control
  output reg                   right_track_ctl,       // Right track control
  output reg                   serial_result_out,     // Serial data
  output reg                   array_hold,            // Internal array holds
  output reg  [`SAC_RES_W-1:0] dac_code,              // DAC leg pattern
  output reg                   dummy_lsb,             // Dummy LSB leg
  output reg  [3:0]            trim_sel,              // Bit being trimmed
  output reg  [`SAC_TRIM_W-1:0] trim_val              // Trim for that bit
);
  // ========================================================
  // States
  // ========================================================
  localparam [2:0] ST_CAL   = 3'h0; // Self calibration
  localparam [2:0] ST_TRACK = 3'h1; // Tracking input
  localparam [2:0] ST_SAR   = 3'h2; // Bit decisions
  localparam [2:0] ST_WAIT  = 3'h3; // Wait for S/H window
  localparam [2:0] ST_PUSH  = 3'h4; // Hand result to buffer

  // ========================================================
  // Declarations
  // ========================================================
  wire [3:0]  sync_w;                    // Second sync stage, per pin
  reg         hold_d_r;                  // Strobe, delayed
  reg         sclk_d_r;                  // Serial clock, delayed
  reg  [2:0]  state_r;                   // Control state
  reg  [`SAC_CALCNT_W-1:0] cal_cnt_r;    // Calibration cycles
  reg  [`SAC_TMR_W-1:0]    tmr_r;        // Cycles since strobe fall
  reg         sh1_done_r;                // First S/H has fallen
  reg  [3:0]  step_r;                    // Settle counter
  reg  [3:0]  bit_r;                     // Bit under test
  reg  [2:0]  tstep_r;                   // Trim tries on bit
  reg  [`SAC_RES_W-1:0] res_r;           // Kept bits
  reg  [`SAC_RES_W-1:0] word_r;          // Coded result
  reg  [`SAC_RES_W-1:0] shift_r;         // Serial shifter
  // (RQ9) Kept across reset
  reg  [`SAC_TRIM_W-1:0] trim_mem_r [0:15]; // Coefficients, re-trimmed each cal
  wire        hold_s;                    // Synced strobe
  wire        chan_s;                    // Synced channel select
  wire        sclk_s;                    // Synced serial clock
  wire        twos_s;                    // Synced coding select
  wire        hold_fall;                 // Strobe fell
  wire        sclk_fall;                 // Serial clock fell
  wire        step_end;                  // Decision moment
  wire        push_ready;                // Buffer has room
  wire        pop_valid;                 // Buffer has word
  wire [`SAC_RES_W-1:0] pop_data;        // Oldest word
  wire        pop_take;                  // Shifter loads word
  genvar      gi;

  assign hold_s    = sync_w[0];
  assign chan_s    = sync_w[1];
  assign sclk_s    = sync_w[2];
  assign twos_s    = sync_w[3];
  // Edge detectors reset to the idle level of their pin, so no
  // false edge follows the release of reset
  assign hold_fall = hold_d_r & ~hold_s;
  assign sclk_fall = sclk_d_r & ~sclk_s;
  assign step_end  = (step_r == `SAC_STEP_CYC - 4'h1);
  // (RQ14) Load at any strobe fall outside calibration
  assign pop_take  = hold_fall & (state_r != ST_CAL);

  // ========================================================
  // Saturation and output coding
  // ========================================================
  function [`SAC_RES_W-1:0] f_code;
    input [`SAC_RES_W-1:0] raw;
    input                  pos;
    input                  neg;
    input                  twos;
    reg   [`SAC_RES_W-1:0] sat;
    begin
      sat = raw;
      // (RQ4) Clamp out of range
      if (pos) begin
        sat = `SAC_ALL_ONES;
      end else if (neg) begin
        sat = `SAC_ALL_ZEROS;
      end
      // (RQ5) Offset binary to two's complement
      f_code = twos ? {~sat[`SAC_RES_W-1], sat[`SAC_RES_W-2:0]} : sat;
    end
  endfunction

  // ========================================================
  // Input synchronisers, two flops per pin
  // ========================================================
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      wire pin_w;    // Raw pin
      reg  meta_r;   // First stage
      reg  stage2_r; // Second stage
      // Serial clock idles low, the other pins idle high
      localparam IDLE_LVL = (gi == 2) ? 1'b0 : 1'b1;
      assign pin_w = (gi == 0) ? conv_strobe_n :
                     (gi == 1) ? chan_sel_left :
                     (gi == 2) ? serial_clk : coding_twos;
      assign sync_w[gi] = stage2_r;
      // Second stage is the only reader of the first
      always @(posedge mclk) begin
        if (srst) begin
          meta_r   <= IDLE_LVL;
          stage2_r <= IDLE_LVL;
        end else begin
          meta_r   <= pin_w;
          stage2_r <= meta_r;
        end
      end
    end
  endgenerate

  // ========================================================
  // Result buffer between converter and shifter
  // ========================================================
  sac_fifo2 u_buf (
    .mclk      (mclk),
    .srst      (srst),
    .in_valid  (state_r == ST_PUSH),
    .in_ready  (push_ready),
    .in_data   (word_r),
    .out_valid (pop_valid),
    .out_ready (pop_take),
    .out_data  (pop_data)
  );

  // ========================================================
  // Main control: calibration, tracking, conversion
  // ========================================================
  always @(posedge mclk) begin
    // (RQ12) Reset clears all state except the trim coefficients
    if (srst) begin
      hold_d_r           <= 1'b1;
      sclk_d_r           <= 1'b0; // Serial clock idles low
      state_r            <= ST_CAL;
      cal_cnt_r          <= {`SAC_CALCNT_W{1'b0}};
      tmr_r              <= {`SAC_TMR_W{1'b0}};
      sh1_done_r         <= 1'b0;
      step_r             <= 4'h0;
      bit_r              <= `SAC_MSB;
      tstep_r            <= 3'h0;
      res_r              <= `SAC_ALL_ZEROS;
      word_r             <= `SAC_ALL_ZEROS;
      calib_done_flag    <= 1'b0;
      ext_sh_ctrl_first  <= 1'b1;
      ext_sh_ctrl_second <= 1'b1;
      left_track_ctl     <= 1'b1;
      right_track_ctl    <= 1'b0;
      array_hold         <= 1'b1;
      dac_code           <= `SAC_ALL_ZEROS;
      dummy_lsb          <= 1'b0;
      trim_sel           <= `SAC_MSB;
      trim_val           <= `SAC_TRIM_RST;
    end else begin
      hold_d_r <= hold_s;
      sclk_d_r <= sclk_s;
      step_r   <= step_end ? 4'h0 : step_r + 4'h1;
      case (state_r)
        ST_CAL: begin
          // (RQ11) Flag held low while calibrating
          calib_done_flag <= 1'b0;
          array_hold      <= 1'b1;
          // (RQ8) Bit against lower bits plus dummy
          dac_code  <= `SAC_ALL_ONES >> (5'h10 - {1'b0, bit_r});
          dummy_lsb <= 1'b1;
          trim_sel  <= bit_r;
          trim_val  <= trim_mem_r[bit_r];
          if (step_end) begin
            // Heavy bit steps down, light one steps up
            if (comp_in) begin
              trim_mem_r[bit_r] <= trim_mem_r[bit_r] - 5'h1;
            end else begin
              trim_mem_r[bit_r] <= trim_mem_r[bit_r] + 5'h1;
            end
            tstep_r <= tstep_r + 3'h1;
            if (tstep_r == `SAC_TRIM_STEPS) begin
              // Sweep bits MSB down to 1, then repeat
              bit_r <= (bit_r == 4'h1) ? `SAC_MSB : bit_r - 4'h1;
            end
          end
          // (RQ1) Fixed calibration length
          if (cal_cnt_r == CAL_CYCLES - 1) begin
            state_r         <= ST_TRACK;
            calib_done_flag <= 1'b1;
            array_hold      <= 1'b0;
            dac_code        <= `SAC_ALL_ZEROS;
            dummy_lsb       <= 1'b0;
          end else begin
            cal_cnt_r <= cal_cnt_r + 1'b1;
          end
        end
        ST_TRACK: begin
          // (RQ13) Strobe fall freezes sample
          if (hold_fall) begin
            // (RQ6) Input ignored from here on
            array_hold         <= 1'b1;
            ext_sh_ctrl_second <= 1'b0;
            tmr_r              <= {`SAC_TMR_W{1'b0}};
            sh1_done_r         <= 1'b0;
            bit_r              <= `SAC_MSB;
            step_r             <= 4'h0;
            res_r              <= `SAC_ALL_ZEROS;
            dac_code           <= 16'h8000;
            state_r            <= ST_SAR;
          end
        end
        ST_SAR: begin
          // (RQ7) Keep trial bit if comparator agrees
          if (step_end) begin
            res_r[bit_r] <= comp_in;
            if (bit_r == 4'h0) begin
              state_r <= ST_WAIT;
            end else begin
              bit_r    <= bit_r - 4'h1;
              dac_code <= (res_r | ({15'h0, comp_in} << bit_r))
                          | (16'h0001 << (bit_r - 4'h1));
            end
          end
        end
        ST_WAIT: begin
          // Result waits for the external S/H window
          word_r <= f_code(res_r, over_pos, under_neg, twos_s);
          if (sh1_done_r) begin
            state_r <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          // Stalls here while the buffer is full
          if (push_ready) begin
            // (RQ6) Back to tracking when done
            state_r            <= ST_TRACK;
            array_hold         <= 1'b0;
            dac_code           <= `SAC_ALL_ZEROS;
            ext_sh_ctrl_first  <= 1'b1;
            ext_sh_ctrl_second <= 1'b1;
            // (RQ10) Channel select picks next input
            left_track_ctl     <= chan_s;
            right_track_ctl    <= ~chan_s;
          end
        end
        default: begin
          state_r <= ST_CAL;
        end
      endcase
      // (RQ2) First S/H and tracks fall at fixed count
      if (state_r != ST_CAL && state_r != ST_TRACK && !sh1_done_r) begin
        tmr_r <= tmr_r + 8'h1;
        if (tmr_r == `SAC_SH1_DLY) begin
          sh1_done_r        <= 1'b1;
          ext_sh_ctrl_first <= 1'b0;
          left_track_ctl    <= 1'b0;
          right_track_ctl   <= 1'b0;
        end
      end
    end
  end

  // ========================================================
  // Serial output shifter
  // ========================================================
  always @(posedge mclk) begin
    if (srst) begin
      shift_r           <= `SAC_ALL_ZEROS;
      serial_result_out <= 1'b0;
    end else if (pop_take) begin
      // (RQ15) MSB ready before first rise
      shift_r           <= pop_valid ? pop_data : `SAC_ALL_ZEROS;
      serial_result_out <= pop_valid & pop_data[`SAC_RES_W-1];
    end else if (sclk_fall) begin
      // (RQ15) Change on fall, stable at rise
      shift_r           <= {shift_r[`SAC_RES_W-2:0], 1'b0};
      serial_result_out <= shift_r[`SAC_RES_W-2];
    end
  end
endmodule // sac_top
`default_nettype wire

// file: sim/sac_chk.sv
`default_nettype none
// ========================================
// Port checker for converter control
// ========================================
module sac_chk #(
  parameter int CAL_CYCLES = 64 // Calibration length
) (
  input wire logic        mclk,               // Master clock
  input wire logic        srst,               // Sync reset
  input wire logic        conv_strobe_n,      // Strobe pin
  input wire logic        chan_sel_left,      // Channel select
  input wire logic        calib_done_flag,    // Ready flag
  input wire logic        ext_sh_ctrl_first,  // S/H control 1
  input wire logic        ext_sh_ctrl_second, // S/H control 2
  input wire logic        left_track_ctl,     // Left track
  input wire logic        right_track_ctl,    // Right track
  input wire logic        array_hold,         // Array holds
  input wire logic [15:0] dac_code,           // Trial pattern
  input wire logic        dummy_lsb,          // Dummy leg
  input wire logic [3:0]  trim_sel            // Bit under trim
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  int cal_cnt_r; // Edges since reset release
  // Saturates so a long run never wraps back into the window
  always_ff @(posedge mclk) begin
    if (srst) cal_cnt_r <= 0;
    else if (cal_cnt_r < CAL_CYCLES + 8) cal_cnt_r <= cal_cnt_r + 1;
  end
  // A fall accepted while tracking and ready
  sequence s_go;
    $fell(conv_strobe_n) && calib_done_flag && ext_sh_ctrl_first && ext_sh_ctrl_second;
  endsequence
  property p_cal_low; cal_cnt_r < CAL_CYCLES - 1 |-> !calib_done_flag; endproperty
  a_cal_low: assert property (p_cal_low) else $error("ready flag early");
  property p_cal_done; cal_cnt_r > CAL_CYCLES + 1 |-> calib_done_flag; endproperty
  a_cal_done: assert property (p_cal_done) else $error("ready flag late");
  // Bit under trim faces all lower legs plus the dummy leg
  property p_cal_trim;
    cal_cnt_r > 0 && cal_cnt_r < CAL_CYCLES - 1 |-> dummy_lsb
      && (dac_code + 16'h1) == (16'h1 << trim_sel);
  endproperty
  a_cal_trim: assert property (p_cal_trim) else $error("trim pattern wrong");
  property p_rst;
    disable iff (1'b0) srst |=> !calib_done_flag && ext_sh_ctrl_first && array_hold
      && left_track_ctl && !right_track_ctl && dac_code == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_sh1_win;
    s_go |-> (ext_sh_ctrl_first throughout ##197 1'b1) ##[1:17] !ext_sh_ctrl_first;
  endproperty
  a_sh1_win: assert property (p_sh1_win) else $error("S/H 1 fall outside window");
  property p_hold_start; s_go |-> ##[2:6] (array_hold && !ext_sh_ctrl_second); endproperty
  a_hold_start: assert property (p_hold_start) else $error("no hold after strobe");
  property p_hold_keep; !ext_sh_ctrl_first |-> array_hold; endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("array tracks mid conversion");
  property p_trk_sh; $fell(ext_sh_ctrl_first) |-> !left_track_ctl && !right_track_ctl; endproperty
  a_trk_sh: assert property (p_trk_sh) else $error("track controls not low");
  property p_trk_chan;
    $rose(ext_sh_ctrl_first) |-> !array_hold && left_track_ctl == chan_sel_left
      && right_track_ctl == !chan_sel_left;
  endproperty
  a_trk_chan: assert property (p_trk_chan) else $error("wrong channel tracked");
  property p_sar_first; $rose(array_hold) && calib_done_flag |-> dac_code == 16'h8000; endproperty
  a_sar_first: assert property (p_sar_first) else $error("first trial not MSB");
  property p_sar_step;
    calib_done_flag && array_hold && $changed(dac_code) |=> $stable(dac_code) [*7];
  endproperty
  a_sar_step: assert property (p_sar_step) else $error("trial changed too soon");
  c_cal: cover property ($rose(calib_done_flag));
  c_conv: cover property (s_go);
  c_refused: cover property ($fell(conv_strobe_n) && calib_done_flag && !ext_sh_ctrl_second);
endmodule // sac_chk
`default_nettype wire

// file: sim/sac_gen.sv
`default_nettype none
// ========================================
// Timing generator and serial receiver
// ========================================
module sac_gen (
  input  wire logic mclk,              // Master clock
  output var  logic conv_strobe_n,     // Strobe, fall starts
  output var  logic chan_sel_left,     // Channel select
  output var  logic serial_clk,        // Serial clock, idles low
  input  wire logic serial_result_out  // Serial data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    conv_strobe_n = 1'b1;
    chan_sel_left = 1'b1;
    serial_clk = 1'b0;
  end
  // One strobe frame of period cycles; short frames send no clock
  task automatic frame(output logic [15:0] word, input int period);
    logic [15:0] sh;
    sh = 16'h0000;
    @(posedge mclk);
    conv_strobe_n <= 1'b0;
    chan_sel_left <= ~chan_sel_left;
    fork
      begin
        repeat (8) @(posedge mclk);
        conv_strobe_n <= 1'b1;
      end
      // 320 ns period: low six cycles, high two; data moves three
      // cycles after each fall, well before the next rise
      if (period >= 140) begin
        repeat (16) begin
          repeat (6) @(posedge mclk);
          serial_clk <= 1'b1;
          sh = {sh[14:0], serial_result_out};
          repeat (2) @(posedge mclk);
          serial_clk <= 1'b0;
        end
      end
      repeat (period - 1) @(posedge mclk);
    join
    word = sh;
  endtask
endmodule // sac_gen
`default_nettype wire

// file: sim/tb_sar_audio_adc_control.sv
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module tb_sar_audio_adc_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAL = 64; // Shortened calibration
  logic        mclk, srst, coding_twos, comp_in, over_pos, under_neg; // Drives
  logic        conv_strobe_n, chan_sel_left, serial_clk;             // Generator
  logic        calib_done_flag, ext_sh_ctrl_first, ext_sh_ctrl_second;
  logic        left_track_ctl, right_track_ctl, serial_result_out, array_hold;
  logic [15:0] dac_code, target, w; // Trial, analog stand-in, word
  int          err_count, compares, cyc;
  sac_top #(.CAL_CYCLES(CAL)) uut (.mclk(mclk), .srst(srst), .conv_strobe_n(conv_strobe_n),
    .chan_sel_left(chan_sel_left), .serial_clk(serial_clk), .coding_twos(coding_twos),
    .comp_in(comp_in), .over_pos(over_pos), .under_neg(under_neg),
    .calib_done_flag(calib_done_flag), .ext_sh_ctrl_first(ext_sh_ctrl_first),
    .ext_sh_ctrl_second(ext_sh_ctrl_second), .left_track_ctl(left_track_ctl),
    .right_track_ctl(right_track_ctl), .serial_result_out(serial_result_out),
    .array_hold(array_hold), .dac_code(dac_code), .dummy_lsb(), .trim_sel(), .trim_val());
  sac_gen u_gen (.mclk(mclk), .conv_strobe_n(conv_strobe_n), .chan_sel_left(chan_sel_left),
    .serial_clk(serial_clk), .serial_result_out(serial_result_out));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Comparator: keep the trial while it does not exceed the held sample
  always @(posedge mclk) comp_in <= (dac_code <= target);
  // Hang guard, well above the few thousand cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_calib();
    int n;
    srst <= 1'b1;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    n = 0;
    repeat (CAL - 2) begin
      @(posedge mclk);
      if (calib_done_flag !== 1'b0) n++;
    end
    `CHK("flag low in cal", 0, n)
    n = 0;
    while (calib_done_flag !== 1'b1 && n < 8) begin
      @(posedge mclk);
      n++;
    end
    `CHK("flag rise time", 1'b1, (n >= 2 && n <= 4))
  endtask
  // Codes, range limits and coding; each word shows up one frame later
  task automatic t_codes();
    logic [15:0] tg [7] = '{16'ha5c3, 16'h1234, 16'h0f0f, 16'h0f0f, 16'h7777, 16'h5a3c, 16'h4444};
    logic [6:0]  ov = 7'b0010100;
    logic [6:0]  un = 7'b1001000;
    logic [6:0]  tw = 7'b1100110;
    logic [15:0] ex, prev;
    prev = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      if (i < 7) begin
        target <= tg[i];
        over_pos <= ov[i];
        under_neg <= un[i];
        coding_twos <= tw[i];
      end
      u_gen.frame(w, 256);
      `CHK("serial word", prev, w)
      if (i < 7) begin
        ex = ov[i] ? 16'hffff : (un[i] ? 16'h0000 : tg[i]);
        prev = ex ^ (tw[i] ? 16'h8000 : 16'h0000);
      end
    end
    // Below range in two's complement is the most negative code
    `CHK("flushed word", 16'h8000, w)
  endtask
  // Strobe fall mid conversion must not restart it
  task automatic t_refuse();
    @(posedge mclk);
    target <= 16'h0f0f;
    over_pos <= 1'b0;
    under_neg <= 1'b0;
    coding_twos <= 1'b0;
    u_gen.frame(w, 100);
    fork
      u_gen.frame(w, 256);
      begin
        repeat (150) @(posedge mclk);
        `CHK("track after refuse", 1'b1, ext_sh_ctrl_first === 1'b1 && array_hold === 1'b0)
      end
    join
    u_gen.frame(w, 256);
    `CHK("word of kept conv", 16'h0f0f, w)
  endtask
  // Reset in mid conversion clears it and recalibrates
  task automatic t_reset_mid();
    @(posedge mclk);
    target <= 16'h3c3c;
    fork
      u_gen.frame(w, 256);
      begin
        repeat (60) @(posedge mclk);
        srst <= 1'b1;
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        `CHK("flag cleared", 1'b0, calib_done_flag)
        `CHK("tracking again", 1'b1, ext_sh_ctrl_first)
      end
    join
    `CHK("recalibrated", 1'b1, calib_done_flag)
    u_gen.frame(w, 256);
    `CHK("buffer cleared", 16'h0000, w)
    u_gen.frame(w, 256);
    `CHK("word after recal", 16'h3c3c, w)
  endtask
  initial begin
    srst = 1'b1;
    coding_twos = 1'b0;
    comp_in = 1'b0;
    over_pos = 1'b0;
    under_neg = 1'b0;
    target = 16'h0000;
    t_calib();
    t_codes();
    t_refuse();
    t_reset_mid();
    finish_test();
  end
endmodule // tb_sar_audio_adc_control
bind sac_top sac_chk #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.mclk(mclk), .srst(srst),
  .conv_strobe_n(conv_strobe_n), .chan_sel_left(chan_sel_left),
  .calib_done_flag(calib_done_flag), .ext_sh_ctrl_first(ext_sh_ctrl_first),
  .ext_sh_ctrl_second(ext_sh_ctrl_second), .left_track_ctl(left_track_ctl),
  .right_track_ctl(right_track_ctl), .array_hold(array_hold), .dac_code(dac_code),
  .dummy_lsb(dummy_lsb), .trim_sel(trim_sel));
`default_nettype wire
